// *** logic/msfc_map.svh ***
// Constants of the mote serial port: framing, timing and character format
`ifndef MSFC_MAP_SVH
`define MSFC_MAP_SVH
`define MSFC_CLK_HZ      250000000
`define MSFC_BAUD        4800
`define MSFC_BAUD_DIV    (`MSFC_CLK_HZ / `MSFC_BAUD)
`define MSFC_DATA_BITS   8
`define MSFC_BOOT_MS     250
`define MSFC_BOOT_CYC    (`MSFC_CLK_HZ / 1000 * `MSFC_BOOT_MS)
`define MSFC_RESP_MS     100
`define MSFC_RESP_CYC    (`MSFC_CLK_HZ / 1000 * `MSFC_RESP_MS)
`define MSFC_MAX_PAYLOAD 80
`define MSFC_FLAG        8'h7E
`define MSFC_ESC         8'h7D
`define MSFC_ESC_XOR     8'h20
`define MSFC_FCS_INIT    16'hFFFF
`define MSFC_FCS_GOOD    16'hF0B8
`define MSFC_FCS_POLY    16'h8408
`define MSFC_CMD_DATA    8'h80
`define MSFC_CMD_INFO    8'h8C
`endif

// *** logic/msfc_pkg.sv ***
// Types of the mote serial port
package msfc_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } msfc_rx_state_type;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_OPEN  = 3'b001,
    TX_BODY  = 3'b010,
    TX_FCS_L = 3'b011,
    TX_FCS_H = 3'b100,
    TX_CLOSE = 3'b101
  } msfc_tx_state_type;
endpackage

// *** logic/msfc_serial_port.sv ***
// Mote host serial port: character framing, HDLC framing, clear-to-send and boot
`include "msfc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Characters run at 4800 baud with one start bit, eight data bits and no parity.
// - The clear-to-send output is active low: low lets the host send.
// - Clear-to-send is high from reset until the port is ready for data packets.
// - The serial port becomes operational no later than 250 ms after reset.
// - On becoming operational the port sends one device-information frame unasked.
// - Clear-to-send goes low only once the device has joined the network.
// - Clear-to-send stays high while there is no room for one more data packet.
// - Clear-to-send stays high while the device is not a network member.
// - Clear-to-send may also be raised during critical communication intervals.
// - Command and diagnostic frames are received whatever clear-to-send shows.
// - Every host request is answered within 100 ms, else it is flagged overdue.
// - Flow control covers host-to-device traffic only; transmit never waits on the host.
// - Frames use async HDLC with a 16-bit check; frames that fail have their bytes passed on and are flagged bad at the closing flag.
// - Payloads are at most 80 bytes and numbers go most significant byte first.
module msfc_serial_port
  import msfc_pkg::*;
#(
  parameter int           BAUD_DIV  = `MSFC_BAUD_DIV,
  parameter int           BOOT_CYC  = `MSFC_BOOT_CYC,
  parameter int           RESP_CYC  = `MSFC_RESP_CYC,
  parameter logic [7:0]   INFO_BYTE = 8'h01  // Arbitrary device-information value
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // Serial pins
  input  wire logic       i_rx,
  output logic            o_tx,
  output logic            o_cts_n,
  // Device status
  input  wire logic       i_joined,
  input  wire logic       i_pkt_space,
  input  wire logic       i_critical,
  output logic            o_ready,
  // Received frame bytes
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_good,
  output logic            o_rx_bad,
  // Frame to transmit
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  input  wire logic       i_tx_last,
  output logic            o_tx_ready,
  // Request tracking
  output logic            o_req_pending,
  output logic            o_resp_overdue
);

  localparam int HALF_DIV = BAUD_DIV / 2;
  localparam int CW       = $clog2(((BOOT_CYC > RESP_CYC) ? BOOT_CYC : RESP_CYC) + 1);  // Wide enough for both timers
  localparam int MAX_LEN  = `MSFC_MAX_PAYLOAD + 3;

  // One byte of the 16-bit frame check, reflected
  function automatic logic [15:0] fcs_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ `MSFC_FCS_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Bytes that would look like framing must be escaped
  function automatic logic needs_esc(input logic [7:0] b);
    return (b == `MSFC_FLAG) || (b == `MSFC_ESC);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Boot, clear-to-send and request timer
  logic [CW-1:0] boot_cnt, next_boot_cnt;
  logic          booted, next_booted;
  logic          announce, next_announce;
  logic          req, next_req;
  logic          overdue, next_overdue;
  logic [CW-1:0] resp_cnt, next_resp_cnt;
  logic          frame_start, ann_end;
  logic          req_seen;

  // Boot counter then request watchdog
  always_comb begin
    next_boot_cnt = boot_cnt;
    next_booted   = booted;
    next_announce = announce;
    next_req      = req;
    next_overdue  = overdue;
    next_resp_cnt = resp_cnt;
    if (!booted) begin
      next_boot_cnt = boot_cnt + 1'b1;
      if (boot_cnt == CW'(BOOT_CYC - 1)) begin
        next_booted   = 1'b1;
        next_announce = 1'b1;
      end
    end
    if (ann_end) begin  // Body mux stays on the announcement until its check bytes
      next_announce = 1'b0;
    end
    // A reply starting ends the wait; a new request restarts it
    if (req_seen) begin
      next_req      = 1'b1;
      next_resp_cnt = '0;
      next_overdue  = 1'b0;
    end else if (frame_start && !announce) begin
      next_req = 1'b0;
    end else if (req) begin
      next_resp_cnt = resp_cnt + 1'b1;
      if (resp_cnt == CW'(RESP_CYC - 1)) begin
        next_overdue = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      boot_cnt <= '0;
      booted   <= 1'b0;
      announce <= 1'b0;
      req      <= 1'b0;
      overdue  <= 1'b0;
      resp_cnt <= '0;
    end else begin
      boot_cnt <= next_boot_cnt;
      booted   <= next_booted;
      announce <= next_announce;
      req      <= next_req;
      overdue  <= next_overdue;
      resp_cnt <= next_resp_cnt;
    end
  end

  // Host may send data only when every condition allows; host obeys per packet
  assign o_cts_n        = !(booted && i_joined && i_pkt_space && !i_critical);
  assign o_ready        = booted;
  assign o_req_pending  = req;
  assign o_resp_overdue = overdue;

  //////////////////////////////////////////////////////////////////////////////
  // Receiver: character and frame decode
  msfc_rx_state_type rx_st, next_rx_st;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [2:0]  rx_bit, next_rx_bit;
  logic [7:0]  rx_sh, next_rx_sh;
  logic        in_esc, next_in_esc;
  logic        rx_err, next_rx_err;
  logic [15:0] rx_fcs, next_rx_fcs;
  logic [6:0]  rx_len, next_rx_len;
  logic [7:0]  dly0, next_dly0, dly1, next_dly1;
  logic [7:0]  rx_cmd, next_rx_cmd;
  logic [7:0]  next_rx_data;
  logic        next_rx_valid, next_rx_good, next_rx_bad;
  logic        byte_ok;
  logic [7:0]  b;

  always_comb begin
    next_rx_st = rx_st;  next_rx_cnt = rx_cnt + 1'b1;
    next_rx_bit = rx_bit; next_rx_sh = rx_sh;
    next_in_esc = in_esc; next_rx_err = rx_err;
    next_rx_fcs = rx_fcs; next_rx_len = rx_len;
    next_dly0 = dly0; next_dly1 = dly1; next_rx_cmd = rx_cmd;
    next_rx_data = o_rx_data;
    next_rx_valid = 1'b0; next_rx_good = 1'b0; next_rx_bad = 1'b0;
    byte_ok = 1'b0; req_seen = 1'b0;
    b = rx_sh;
    // Bit timing; ignored until booted, and regardless of clear-to-send
    case (rx_st)
      RX_IDLE: begin
        next_rx_cnt = '0;
        if (booted && !i_rx) next_rx_st = RX_START;
      end
      RX_START: if (rx_cnt == 16'(HALF_DIV - 1)) begin
        next_rx_cnt = '0;
        next_rx_bit = '0;
        next_rx_st  = i_rx ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rx_cnt == 16'(BAUD_DIV - 1)) begin
        next_rx_cnt = '0;
        next_rx_sh  = {i_rx, rx_sh[7:1]};
        next_rx_bit = rx_bit + 1'b1;
        if (rx_bit == 3'(`MSFC_DATA_BITS - 1)) next_rx_st = RX_STOP;
      end
      RX_STOP: if (rx_cnt == 16'(BAUD_DIV - 1)) begin
        next_rx_st = RX_IDLE;
        if (i_rx) byte_ok = 1'b1;
        else next_rx_err = 1'b1;  // Framing error spoils the frame
      end
      default: next_rx_st = RX_IDLE;
    endcase
    // Frame level: flags, escapes, check and a two-byte delay to strip it
    if (byte_ok) begin
      if (rx_sh == `MSFC_FLAG) begin
        if (rx_len >= 7'd3 && !rx_err && rx_fcs == `MSFC_FCS_GOOD) begin
          next_rx_good = 1'b1;
          req_seen = (rx_cmd != `MSFC_CMD_DATA);
        end else if (rx_len != '0) begin
          next_rx_bad = 1'b1;
        end
        next_rx_len = '0; next_rx_err = 1'b0; next_in_esc = 1'b0;
        next_rx_fcs = `MSFC_FCS_INIT;
      end else if (rx_sh == `MSFC_ESC) begin
        next_in_esc = 1'b1;
      end else begin
        b = in_esc ? (rx_sh ^ `MSFC_ESC_XOR) : rx_sh;
        next_in_esc = 1'b0;
        next_rx_fcs = fcs_step(rx_fcs, b);
        next_dly0 = b;
        next_dly1 = dly0;
        if (rx_len == 7'(MAX_LEN)) begin
          next_rx_err = 1'b1;
        end else begin
          next_rx_len = rx_len + 1'b1;
        end
        if (rx_len == 7'd1) next_rx_cmd = dly0;
        if (rx_len >= 7'd2 && !rx_err) begin
          next_rx_data  = dly1;
          next_rx_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rx_st <= RX_IDLE; rx_cnt <= '0; rx_bit <= '0; rx_sh <= '0;
      in_esc <= 1'b0; rx_err <= 1'b0; rx_fcs <= `MSFC_FCS_INIT; rx_len <= '0;
      dly0 <= '0; dly1 <= '0; rx_cmd <= '0;
      o_rx_data <= '0; o_rx_valid <= 1'b0; o_rx_good <= 1'b0; o_rx_bad <= 1'b0;
    end else begin
      rx_st <= next_rx_st; rx_cnt <= next_rx_cnt; rx_bit <= next_rx_bit; rx_sh <= next_rx_sh;
      in_esc <= next_in_esc; rx_err <= next_rx_err; rx_fcs <= next_rx_fcs; rx_len <= next_rx_len;
      dly0 <= next_dly0; dly1 <= next_dly1; rx_cmd <= next_rx_cmd;
      o_rx_data <= next_rx_data; o_rx_valid <= next_rx_valid;
      o_rx_good <= next_rx_good; o_rx_bad <= next_rx_bad;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter: frame encoder feeding one character shifter
  msfc_tx_state_type tx_st, next_tx_st;
  logic [9:0]  tx_sh, next_tx_sh;
  logic [3:0]  tx_bits, next_tx_bits;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [15:0] tx_fcs, next_tx_fcs;
  logic        esc_pend, next_esc_pend;
  logic [7:0]  esc_byte, next_esc_byte;
  logic        ann_idx, next_ann_idx;
  logic        slot;
  logic        send;
  logic [7:0]  sb, body, fl;
  logic        body_ok, body_last;

  // Never waits on the host: its only transmit handshake is o_tx_ready to the local sender
  assign slot = (tx_bits == '0);
  assign body      = announce ? (ann_idx ? INFO_BYTE : `MSFC_CMD_INFO) : i_tx_data;
  assign body_ok   = announce || i_tx_valid;
  assign body_last = announce ? ann_idx : i_tx_last;
  assign o_tx_ready = (tx_st == TX_BODY) && !announce && slot && !esc_pend;
  assign frame_start = (tx_st == TX_IDLE) && booted && (announce || i_tx_valid);
  assign fl = ~tx_fcs[7:0];
  assign ann_end = (tx_st == TX_FCS_L);

  always_comb begin
    next_tx_st = tx_st; next_tx_sh = tx_sh; next_tx_bits = tx_bits;
    next_tx_cnt = tx_cnt; next_tx_fcs = tx_fcs;
    next_esc_pend = esc_pend; next_esc_byte = esc_byte; next_ann_idx = ann_idx;
    send = 1'b0; sb = `MSFC_FLAG;
    // Shift out start, data LSB first, one stop
    if (!slot) begin
      next_tx_cnt = tx_cnt + 1'b1;
      if (tx_cnt == 16'(BAUD_DIV - 1)) begin
        next_tx_cnt  = '0;
        next_tx_sh   = {1'b1, tx_sh[9:1]};
        next_tx_bits = tx_bits - 1'b1;
      end
    end else if (esc_pend) begin
      send = 1'b1; sb = esc_byte; next_esc_pend = 1'b0;
    end else begin
      case (tx_st)
        TX_IDLE: if (frame_start) begin
          next_tx_st = TX_OPEN; next_tx_fcs = `MSFC_FCS_INIT; next_ann_idx = 1'b0;
        end
        TX_OPEN: begin
          send = 1'b1; next_tx_st = TX_BODY;
        end
        TX_BODY: if (body_ok) begin
          send = 1'b1; sb = body;
          next_tx_fcs = fcs_step(tx_fcs, body);
          next_ann_idx = 1'b1;
          if (body_last) next_tx_st = TX_FCS_L;
        end
        TX_FCS_L: begin
          send = 1'b1; sb = fl; next_tx_st = TX_FCS_H;
        end
        TX_FCS_H: begin
          send = 1'b1; sb = ~tx_fcs[15:8]; next_tx_st = TX_CLOSE;
        end
        TX_CLOSE: begin
          send = 1'b1; next_tx_st = TX_IDLE;
        end
        default: next_tx_st = TX_IDLE;
      endcase
      // Escape body and check bytes, never the framing flags
      if (send && (tx_st != TX_OPEN) && (tx_st != TX_CLOSE) && needs_esc(sb)) begin
        next_esc_pend = 1'b1;
        next_esc_byte = sb ^ `MSFC_ESC_XOR;
        sb = `MSFC_ESC;
      end
    end
    if (send) begin
      next_tx_sh   = {1'b1, sb, 1'b0};
      next_tx_bits = 4'd10;
      next_tx_cnt  = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tx_st <= TX_IDLE; tx_sh <= 10'h3FF; tx_bits <= '0; tx_cnt <= '0;
      tx_fcs <= `MSFC_FCS_INIT; esc_pend <= 1'b0; esc_byte <= '0; ann_idx <= 1'b0;
    end else begin
      tx_st <= next_tx_st; tx_sh <= next_tx_sh; tx_bits <= next_tx_bits; tx_cnt <= next_tx_cnt;
      tx_fcs <= next_tx_fcs; esc_pend <= next_esc_pend; esc_byte <= next_esc_byte;
      ann_idx <= next_ann_idx;
    end
  end

  // Idle high between characters
  assign o_tx = slot ? 1'b1 : tx_sh[0];

endmodule  // msfc_serial_port

// *** tb/msfc_serial_port_asserts.sv ***
// Concurrent checks on the mote serial port outputs
module msfc_port_chk #(
  parameter int BOOT_CYC = 200,
  parameter int RESP_CYC = 500
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Pins and status
  input wire logic o_tx,
  input wire logic o_cts_n,
  input wire logic i_joined,
  input wire logic i_pkt_space,
  input wire logic i_critical,
  input wire logic o_ready,
  input wire logic o_rx_good,
  input wire logic o_rx_bad,
  input wire logic o_tx_ready,
  input wire logic o_req_pending,
  input wire logic o_resp_overdue
);
  timeunit 1ns;
  timeprecision 1ps;
  int bcnt;
  int pcnt;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  // Boot cycles and request wait; wait clears and stays at zero once flagged
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bcnt <= 0;
      pcnt <= 0;
    end else begin
      bcnt <= o_ready ? bcnt : bcnt + 1;
      pcnt <= (o_req_pending && !o_resp_overdue) ? pcnt + 1 : 0;
    end
  end
  AST_CTS_EQN: assert property (o_cts_n == !(o_ready && i_joined && i_pkt_space && !i_critical))
    else $error("clear-to-send level wrong");
  AST_BOOT_EARLY: assert property ($rose(o_ready) |-> bcnt >= BOOT_CYC - 1)
    else $error("ready too early");
  AST_BOOT_LATE: assert property (bcnt <= BOOT_CYC + 1)
    else $error("ready too late");
  AST_QUIET_BOOT: assert property (!o_ready |-> o_tx)
    else $error("transmit before boot");
  AST_ANNOUNCE: assert property ($rose(o_ready) |-> ##[0:8] !o_tx)
    else $error("no announcement after boot");
  AST_BIT_WIDTH: assert property ($fell(o_tx) |=> !o_tx [*8])
    else $error("bit shorter than expected");
  AST_GOOD_BAD: assert property (o_rx_good |-> !o_rx_bad ##1 !o_rx_good)
    else $error("frame verdict pulse wrong");
  AST_TX_READY: assert property (o_tx_ready |=> !o_tx_ready [*8])
    else $error("bytes taken too fast");
  AST_RESP_DUE: assert property ($rose(o_resp_overdue) |-> pcnt >= RESP_CYC - 1)
    else $error("overdue too early");
  AST_RESP_LATE: assert property (pcnt <= RESP_CYC + 2)
    else $error("overdue not flagged");
endmodule  // msfc_port_chk

bind msfc_serial_port msfc_port_chk #(.BOOT_CYC(BOOT_CYC), .RESP_CYC(RESP_CYC)) u_chk (
  .i_sys_clk, .i_rst_n, .o_tx, .o_cts_n, .i_joined, .i_pkt_space, .i_critical,
  .o_ready, .o_rx_good, .o_rx_bad, .o_tx_ready, .o_req_pending, .o_resp_overdue);

// *** tb/msfc_host_model.sv ***
// Host microcontroller model on the serial pins
module msfc_host_model #(
  parameter int DIV = 16
) (
  // Clock and device pins
  input  wire logic i_clk,
  input  wire logic i_cts_n,
  input  wire logic i_dev_tx,
  output logic      o_host_tx
);
  timeunit 1ns;
  timeprecision 1ps;
  int         frames = 0;
  logic [7:0] last[$];
  logic [7:0] cur[$];
  logic       esc = 1'b0;
  initial o_host_tx = 1'b1;
  ////////////////////////////////////////
  // Reflected check update; host keeps its own copy
  function automatic logic [15:0] fcs_upd(input logic [15:0] c, input logic [7:0] b);
    c ^= {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  // Start, eight bits LSB first, one stop
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk) o_host_tx = f[i];
      repeat (DIV - 1) @(negedge i_clk);
    end
  endtask
  // Flag and escape codes go out as escape pairs
  task automatic put_esc(input logic [7:0] b);
    if (b == 8'h7E || b == 8'h7D) begin
      put(8'h7D);
      put(b ^ 8'h20);
    end else put(b);
  endtask
  // Whole frame; data packets wait for clear-to-send
  task automatic send_frame(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    if (q[0] == 8'h80) wait (i_cts_n === 1'b0);
    put(8'h7E);
    foreach (q[i]) begin
      put_esc(q[i]);
      c = fcs_upd(c, q[i]);
    end
    c = ~c ^ {15'h0000, bad};
    put_esc(c[7:0]);
    put_esc(c[15:8]);
    put(8'h7E);
  endtask
  // Low pulse shorter than half a bit
  task automatic glitch();
    @(negedge i_clk) o_host_tx = 1'b0;
    repeat (DIV / 2 - 3) @(negedge i_clk);
    o_host_tx = 1'b1;
  endtask
  // Unescape, keep frames whose check holds
  task automatic take(input logic [7:0] b);
    logic [15:0] c;
    c = 16'hFFFF;
    if (b == 8'h7E) begin
      foreach (cur[i]) c = fcs_upd(c, cur[i]);
      if (cur.size() >= 3 && c == 16'hF0B8) begin
        frames++;
        last = cur[0:$-2];
      end
      cur = {};
    end else if (b == 8'h7D) esc = 1'b1;
    else begin
      cur.push_back(esc ? b ^ 8'h20 : b);
      esc = 1'b0;
    end
  endtask
  // Receiver is always ready, no handshake back
  initial forever begin : rx_loop
    logic [7:0] b;
    @(negedge i_dev_tx);
    repeat (DIV / 2) @(posedge i_clk);
    if (i_dev_tx === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge i_clk);
        b[i] = i_dev_tx;
      end
      repeat (DIV) @(posedge i_clk);
      take(b);
    end
  end
endmodule  // msfc_host_model

// *** tb/tb_mote_serial_flow_control.sv ***
// Bench of the mote serial port: boot, flow control, frames, replies
module tb_mote_serial_flow_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         DIV  = 16;
  localparam int         BOOT = 200;
  localparam int         RESP = 500;
  localparam logic [7:0] INFO = 8'h5A;  // Arbitrary value
  logic       sys_clk = 0, rst_n = 0, joined = 0, space = 0, crit = 0, tx_valid = 0, tx_last = 0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_data;
  logic       rx, tx, cts_n, ready, rx_valid, rx_good, rx_bad, tx_ready, pend, late;
  int         mismatches = 0, compares = 0, n_good = 0, n_bad = 0;
  logic [7:0] rxq[$];
  ////////////////////////////////////////
  msfc_serial_port #(.BAUD_DIV(DIV), .BOOT_CYC(BOOT), .RESP_CYC(RESP), .INFO_BYTE(INFO)) u_dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_rx(rx), .o_tx(tx), .o_cts_n(cts_n),
    .i_joined(joined), .i_pkt_space(space), .i_critical(crit), .o_ready(ready),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_good(rx_good), .o_rx_bad(rx_bad),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
    .o_req_pending(pend), .o_resp_overdue(late));
  msfc_host_model #(.DIV(DIV)) u_host (.i_clk(sys_clk), .i_cts_n(cts_n), .i_dev_tx(tx), .o_host_tx(rx));
  // 4 ns clock
  initial forever #2 sys_clk = ~sys_clk;
  // One-cycle pulses are caught mid-cycle
  always @(negedge sys_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    n_good += int'(rx_good === 1'b1);
    n_bad += int'(rx_bad === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_frames(input int n);
    repeat (4000) if (u_host.frames < n) @(negedge sys_clk);
    chk(u_host.frames, n, "frame missing");
  endtask
  // Held until the edge that takes each byte
  task automatic send_tx(input logic [7:0] q[$]);
    foreach (q[i]) begin
      tx_data = q[i];
      tx_last = (i == q.size() - 1);
      tx_valid = 1'b1;
      repeat (2000) begin
        @(negedge sys_clk);
        if (tx_ready === 1'b1) break;
      end
      @(negedge sys_clk);
    end
    tx_valid = 1'b0;
    tx_last = 1'b0;
  endtask
  ////////////////////////////////////////
  // Quiet lines during boot even when joined
  task automatic t_boot();
    int n = 0;
    {joined, space} = 2'h3;
    while (ready !== 1'b1 && n < 2 * BOOT) begin
      chk({cts_n, tx}, 2'h3, "active during boot");
      @(negedge sys_clk);
      n++;
    end
    chk(n >= BOOT - 1 && n <= BOOT + 1, 1, "boot time");
    chk(cts_n, 0, "cts after boot");
    wait_frames(1);
    chk({u_host.last[0], u_host.last[1]}, {8'h8C, INFO}, "announcement");
    $display("t_boot done");
  endtask
  task automatic t_cts();
    for (int i = 0; i < 8; i++) begin
      {joined, space, crit} = 3'(i);
      #1;
      chk(cts_n, i != 6, "cts level");
      @(negedge sys_clk);
    end
    {joined, crit} = 2'h0;
    $display("t_cts done");
  endtask
  // Command while cts high; reply late, then sent
  task automatic t_cmd();
    u_host.send_frame({8'h89, 8'h7E}, 1'b0);
    repeat (8) @(negedge sys_clk);
    chk(rxq.size(), 2, "byte count");
    chk({rxq[0], rxq[1], n_good[0]}, 17'h1_12FD, "command");
    chk(pend, 1, "no request");
    repeat (RESP + 20) @(negedge sys_clk);
    chk(late, 1, "not overdue");
    send_tx({8'h8A, 8'h12, 8'h34});
    chk(pend, 0, "reply ignored");
    wait_frames(2);
    chk({u_host.last[0], u_host.last[1], u_host.last[2]}, 24'h8A_1234, "reply");
    $display("t_cmd done");
  endtask
  // Corrupt check: refused, no request
  task automatic t_bad();
    u_host.send_frame({8'h87, 8'h05}, 1'b1);
    repeat (8) @(negedge sys_clk);
    chk({n_good[7:0], n_bad[7:0], pend}, 17'h0_0202, "bad frame");
    $display("t_bad done");
  endtask
  // Data held back by a critical interval
  task automatic t_data();
    rxq = {};
    {joined, crit} = 2'h3;
    fork
      u_host.send_frame({8'h80, 8'h55}, 1'b0);
      begin
        repeat (300) @(negedge sys_clk);
        chk(rxq.size(), 0, "sent while cts high");
        crit = 1'b0;
      end
    join
    repeat (8) @(negedge sys_clk);
    chk({rxq[0], rxq[1], n_good[0], pend}, 18'h2_0154, "data");
    $display("t_data done");
  endtask
  // Short low pulse is no start bit
  task automatic t_glitch();
    u_host.glitch();
    repeat (20 * DIV) @(negedge sys_clk);
    u_host.send_frame({8'h89, 8'h01}, 1'b0);
    repeat (8) @(negedge sys_clk);
    chk({n_good[7:0], n_bad[7:0]}, 16'h0301, "glitch");
    $display("t_glitch done");
  endtask
  // Hang guard
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    $display("CHECK FAILED at %0t: timeout", $time);
    complete_run();
  end
  // Reset four cycles, then scenarios
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    t_boot();
    t_cts();
    t_cmd();
    t_bad();
    t_data();
    t_glitch();
    complete_run();
  end
endmodule  // tb_mote_serial_flow_control
